/* File: verilog/mrc_pkg.sv */
`default_nettype none
package mrc_pkg;
  // Instruction word layout
  localparam int MRC_IW = 14;
  localparam logic [13:0] MRC_OP_CFG_LOAD = 14'h0062; // Legacy config load
  localparam logic [13:0] MRC_OP_IRQ_RET = 14'h0009; // Return from interrupt
  localparam logic [13:0] MRC_MOVE_MASK = 14'h3F80; // Fixed bits of move
  localparam logic [13:0] MRC_MOVE_PAT = 14'h0080; // Move pattern
  localparam logic [13:0] MRC_IDLE_MASK = 14'h3F9F; // Fixed bits of idle
  localparam logic [13:0] MRC_IDLE_PAT = 14'h0000; // Idle pattern
  // Interrupt control register
  localparam int MRC_GLOBAL_IRQ_ENABLE_BIT = 7; // Global enable bit position
  localparam logic [6:0] MRC_IRQ_CTRL_ADDR = 7'h0B; // Address of irq control
  localparam logic [6:0] MRC_CFG_ADDR = 7'h01; // File address of config reg
  localparam logic [7:0] MRC_CFG_RESET = 8'hFF; // Config value after reset
  localparam logic [7:0] MRC_IRQ_RESET = 8'h00; // Irq control after reset
  localparam logic [1:0] MRC_PHASE_RESET = 2'h0; // Phase after reset
  localparam logic [1:0] MRC_PH_Q2 = 2'h1; // Second phase
  localparam logic [1:0] MRC_PH_Q3 = 2'h2; // Third phase
  localparam logic [1:0] MRC_PH_Q4 = 2'h3; // Fourth phase
  // Decoded instruction kinds
  typedef enum logic [2:0] {MRC_K_IDLE, MRC_K_MOVE, MRC_K_RET, MRC_K_CFG, MRC_K_OTHER} mrc_kind_e;
endpackage : mrc_pkg
`default_nettype wire

/* File: verilog/mrc_decode.sv */
`timescale 1ns/100ps
`default_nettype none
module mrc_decode
  import mrc_pkg::*;
(
  input wire logic [13:0] iw, // Instruction word
  output mrc_kind_e kind // Decoded kind
);
  ////////////////////////////////////////////////////////////////
  // Pattern match, exact words first
  always_comb
  begin
    if (iw == MRC_OP_CFG_LOAD)
      kind = MRC_K_CFG;
    else if (iw == MRC_OP_IRQ_RET)
      kind = MRC_K_RET;
    else if ((iw & MRC_MOVE_MASK) == MRC_MOVE_PAT)
      kind = MRC_K_MOVE;
    else if ((iw & MRC_IDLE_MASK) == MRC_IDLE_PAT)
      kind = MRC_K_IDLE;
    else
      kind = MRC_K_OTHER;
  end
endmodule : mrc_decode
`default_nettype wire

/* File: verilog/mrc_exec.sv */
`timescale 1ns/100ps
`default_nettype none
module mrc_exec
  import mrc_pkg::*;
(
  input wire logic CLK, // Core clock
  input wire logic RST_N, // Sync reset, active low
  input wire logic [13:0] IWORD, // Instruction word, held for cycle
  input wire logic [7:0] WREG, // Working accumulator
  input wire logic [7:0] FILE_RDATA, // Read data of other file regs
  output logic [1:0] PHASE, // Current phase, 0..3
  output logic FETCH, // High in phase 4 when next word due
  output logic FILE_WE, // File write strobe
  output logic [6:0] FILE_ADDR, // File write address
  output logic [7:0] FILE_WDATA, // File write data
  output logic STACK_POP, // Stack pop strobe into PC
  output logic GLOBAL_IRQ_ENABLE, // Global irq enable level
  output logic [7:0] CFG_REG, // Timer prescaler config register
  output logic [7:0] RDATA // Read data at file address
);
  ////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [1:0] phase; // Phase counter
    logic idle2; // Second, idle cycle of a return
    logic [7:0] cfg; // Config register
    logic [7:0] irq; // Irq control register
    logic we; // Write strobe
    logic [6:0] addr; // Write address
    logic [7:0] wdata; // Write data
    logic pop; // Pop strobe
  } mrc_state_s;

  mrc_state_s st; // Registered state
  mrc_state_s next_st; // Next state
  mrc_kind_e kind; // Decoded kind

  ////////////////////////////////////////////////////////////////
  // Address match, shared by the commit and the readback path
  function automatic logic addr_hit(input logic [6:0] addr, input logic [6:0] target);
    return addr == target;
  endfunction : addr_hit

  ////////////////////////////////////////////////////////////////
  // Decoder
  mrc_decode u_dec (
    .iw(IWORD),
    .kind(kind)
  );

  ////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    next_st = st;
    next_st.phase = st.phase + 2'd1;
    next_st.we = 1'b0;
    next_st.pop = 1'b0;
    // Writes by address from other instructions are outside; move only here
    if (st.phase == MRC_PHASE_RESET && !st.idle2)
    begin
      case (kind)
        MRC_K_MOVE:
        begin
          // Move: commit to file in phase four
          next_st.addr = IWORD[6:0];
          next_st.wdata = WREG;
        end
        default:
        begin
          next_st.addr = st.addr;
        end
      endcase
    end
    if (st.phase == MRC_PH_Q3 && !st.idle2)
    begin
      case (kind)
        MRC_K_MOVE:
        begin
          next_st.we = 1'b1;
          // Commit the data captured in phase one, so that the file
          // strobe and the mirrored registers always carry one value
          if (addr_hit(st.addr, MRC_CFG_ADDR))
            next_st.cfg = st.wdata;
          if (addr_hit(st.addr, MRC_IRQ_CTRL_ADDR))
            next_st.irq = st.wdata;
        end
        MRC_K_CFG:
          next_st.cfg = WREG;
        MRC_K_RET:
          next_st.pop = 1'b1;
        default:
          next_st.we = 1'b0; // Idle and others: nothing here
      endcase
    end
    // Global enable set in third phase of the return
    if (st.phase == MRC_PH_Q2 && !st.idle2 && kind == MRC_K_RET)
      next_st.irq[MRC_GLOBAL_IRQ_ENABLE_BIT] = 1'b1;
    // Second cycle of the return is idle
    if (st.phase == MRC_PH_Q4)
      next_st.idle2 = !st.idle2 && kind == MRC_K_RET;
  end

  ////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      st <= '0;
      st.phase <= MRC_PHASE_RESET;
      st.cfg <= MRC_CFG_RESET;
      st.irq <= MRC_IRQ_RESET;
    end
    else
      st <= next_st;
  end

  ////////////////////////////////////////////////////////////////
  // Outputs
  assign PHASE = st.phase;
  // No fetch at the end of a return's first cycle: the word must
  // stand through the idle second cycle as well
  assign FETCH = (st.phase == MRC_PH_Q4) && !(kind == MRC_K_RET && !st.idle2);
  assign FILE_WE = st.we;
  assign FILE_ADDR = st.addr;
  assign FILE_WDATA = st.wdata;
  assign STACK_POP = st.pop;
  assign GLOBAL_IRQ_ENABLE = st.irq[MRC_GLOBAL_IRQ_ENABLE_BIT];
  assign CFG_REG = st.cfg;
  // Readback of config and irq control by file address
  assign RDATA = addr_hit(IWORD[6:0], MRC_CFG_ADDR) ? st.cfg :
                 addr_hit(IWORD[6:0], MRC_IRQ_CTRL_ADDR) ? st.irq : FILE_RDATA;

  ////////////////////////////////////////////////////////////////
  // Checks
  // All checks run on the core clock and sleep through reset.
  // They watch what this block drives, plus its WREG and IWORD inputs.

  // Config load takes the accumulator
  // seen in the third phase
  chk_cfg_load: assert property (@(posedge CLK) disable iff (!RST_N)
    (st.phase == MRC_PH_Q3 && !st.idle2 && kind == MRC_K_CFG) |=> (CFG_REG == $past(WREG)))
    else $error("config load missed");
  // Return sets the enable in phase three,
  // then pops in phase four
  chk_ret_enable: assert property (@(posedge CLK) disable iff (!RST_N)
    (st.phase == MRC_PH_Q2 && !st.idle2 && kind == MRC_K_RET) |=> GLOBAL_IRQ_ENABLE ##1 STACK_POP)
    else $error("return enable or pop wrong");
  // Four idle phases follow the pop
  // with no file strobe
  chk_ret_idle: assert property (@(posedge CLK) disable iff (!RST_N)
    STACK_POP |=> (st.idle2 && !FILE_WE) [*4])
    else $error("return second cycle not idle");
  // Move data is the accumulator of phase one,
  // written in phase four
  chk_move_we: assert property (@(posedge CLK) disable iff (!RST_N)
    FILE_WE |-> (PHASE == MRC_PH_Q4) && (FILE_WDATA == $past(WREG, 3)))
    else $error("move write wrong phase");
  // Config load never opens
  // a second cycle
  chk_one_cycle: assert property (@(posedge CLK) disable iff (!RST_N)
    (FETCH && !st.idle2 && kind == MRC_K_CFG) |=> !st.idle2)
    else $error("config load not one cycle");
  // A move to the config address
  // lands in the config register
  chk_cfg_addr: assert property (@(posedge CLK) disable iff (!RST_N)
    (FILE_WE && FILE_ADDR == MRC_CFG_ADDR) |-> CFG_REG == FILE_WDATA)
    else $error("config not file addressable");
  // Phase counter steps by one
  // on every clock
  chk_phase_step: assert property (@(posedge CLK) disable iff (!RST_N)
    1'b1 |=> PHASE == $past(PHASE) + 2'h1)
    else $error("phase did not step");
  // File strobe is a single
  // clock pulse
  chk_we_pulse: assert property (@(posedge CLK) disable iff (!RST_N)
    FILE_WE |=> !FILE_WE)
    else $error("file strobe too long");
  // Pop only in phase four, and the word
  // is not replaced at that point
  chk_pop_phase: assert property (@(posedge CLK) disable iff (!RST_N)
    STACK_POP |-> (PHASE == MRC_PH_Q4) && !FETCH)
    else $error("pop in wrong phase");
  // Idle and unknown words
  // raise no strobe
  chk_idle_quiet: assert property (@(posedge CLK) disable iff (!RST_N)
    (PHASE == MRC_PHASE_RESET && !st.idle2 && (kind == MRC_K_IDLE || kind == MRC_K_OTHER))
    |=> (!FILE_WE && !STACK_POP) [*4])
    else $error("idle word had an effect");
  // Config changes only on entry
  // to phase four
  chk_cfg_steady: assert property (@(posedge CLK) disable iff (!RST_N)
    (PHASE != MRC_PH_Q4) |-> $stable(CFG_REG))
    else $error("config changed off phase");
  // Enable never changes on entry
  // to phase one or two
  chk_enable_steady: assert property (@(posedge CLK) disable iff (!RST_N)
    (PHASE == MRC_PHASE_RESET || PHASE == MRC_PH_Q2) |-> $stable(GLOBAL_IRQ_ENABLE))
    else $error("enable changed off phase");
  // Write address is the field
  // of the word in phase one
  chk_move_addr: assert property (@(posedge CLK) disable iff (!RST_N)
    FILE_WE |-> FILE_ADDR == $past(IWORD[6:0], 3))
    else $error("move address wrong");
  // Moves elsewhere leave
  // the config register alone
  chk_cfg_other: assert property (@(posedge CLK) disable iff (!RST_N)
    (FILE_WE && FILE_ADDR != MRC_CFG_ADDR) |-> $stable(CFG_REG))
    else $error("config hit by other move");
  // Idle second cycle opens
  // only after a pop
  chk_idle2_cause: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(st.idle2) |-> $past(STACK_POP))
    else $error("idle cycle without return");
endmodule : mrc_exec
`default_nettype wire

/* File: dv/mrc_prog_mem.sv */
`timescale 1ns/100ps
`default_nettype none
// Program memory model: hands over a word on each fetch
module mrc_prog_mem (
  input wire logic CLK, // Core clock
  input wire logic RST_N, // Sync reset, active low
  input wire logic FETCH, // Next word due
  input wire logic [13:0] NEXT_WORD, // Word to hand over
  output logic [13:0] IWORD // Word held for the core
);
  // Word stands until the core fetches again, both cycles of a return
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      IWORD <= 14'h0000;
    else if (FETCH)
      IWORD <= NEXT_WORD;
  end
endmodule : mrc_prog_mem
`default_nettype wire

/* File: dv/misc_move_return_config_exec_test.sv */
`timescale 1ns/100ps
`default_nettype none
module misc_move_return_config_exec_test;
  import mrc_pkg::*;
  logic clk, rst_n, fetch, file_we, stack_pop, global_irq_enable; // Clock, reset, strobes
  logic [13:0] iword, next_word; // Word at core, word queued
  logic [7:0] wreg, file_rdata, file_wdata, cfg_reg, rdata, wd; // Data
  logic [6:0] file_addr, wa; // Write address, captured address
  logic [1:0] phase; // Phase
  int mismatches, checks_done, clks, wes, pops; // Counters
  mrc_prog_mem mem (.CLK(clk), .RST_N(rst_n), .FETCH(fetch), .NEXT_WORD(next_word),
    .IWORD(iword));
  mrc_exec dut (.CLK(clk), .RST_N(rst_n), .IWORD(iword), .WREG(wreg),
    .FILE_RDATA(file_rdata), .PHASE(phase), .FETCH(fetch), .FILE_WE(file_we),
    .FILE_ADDR(file_addr), .FILE_WDATA(file_wdata), .STACK_POP(stack_pop),
    .GLOBAL_IRQ_ENABLE(global_irq_enable), .CFG_REG(cfg_reg), .RDATA(rdata));
  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // Run one word from its fetch to the next fetch, counting strobes
  task automatic exec(input logic [13:0] word, input logic [7:0] w);
    next_word <= word;
    wreg <= w;
    clks = 0;
    do @(posedge clk); while (fetch !== 1'b1 && ++clks < 20);
    next_word <= 14'h0000;
    {clks, wes, pops} = 0;
    do
    begin
      @(posedge clk);
      clks++;
      wes += file_we;
      pops += stack_pop;
      if (file_we === 1'b1)
        {wa, wd} = {file_addr, file_wdata};
    end
    while (fetch !== 1'b1 && clks < 20);
  endtask : exec
  ////////////////////////////////////////////////////////////////////////////
  // Legacy config load, one cycle, no file strobe
  task automatic t_cfg_load;
    exec(14'h0062, 8'hA5);
    check("cfg", cfg_reg, 8'hA5);
    check("cycles", 8'(clks), 8'h04);
    check("we", 8'(wes), 8'h00);
  endtask : t_cfg_load
  // Moves to a plain file and to the config address
  task automatic t_move;
    exec(14'h00C5, 8'h3C);
    check("we", 8'(wes), 8'h01);
    check("addr", {1'b0, wa}, 8'h45);
    check("data", wd, 8'h3C);
    check("cycles", 8'(clks), 8'h04);
    check("rdata", rdata, 8'h96);
    exec(14'h0081, 8'h5A); // Direct addressing
    check("cfg", cfg_reg, 8'h5A);
    check("rdata", rdata, 8'h5A);
  endtask : t_move
  // Return pops once, sets enable, two cycles; move to irq reg clears it
  task automatic t_irq_ret;
    exec(14'h0009, 8'h00);
    check("cycles", 8'(clks), 8'h08);
    check("pops", 8'(pops), 8'h01);
    check("irq_enable", {7'h00, global_irq_enable}, 8'h01);
    exec(14'h008B, 8'h00);
    check("irq_enable", {7'h00, global_irq_enable}, 8'h00);
  endtask : t_irq_ret
  // Idle with don't-care bits set and an unknown word change nothing
  task automatic t_idle;
    exec(14'h0060, 8'h77);
    check("cycles", 8'(clks), 8'h04);
    check("we", 8'(wes + pops), 8'h00);
    exec(14'h3FFF, 8'h11);
    check("cfg", cfg_reg, 8'h5A);
  endtask : t_idle
  // Print counts and verdict, then stop
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////
  // Clock of 5 ns
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Main sequence
  initial
  begin
    {rst_n, next_word, wreg, file_rdata} = {1'b0, 14'h0000, 8'h00, 8'h96};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("cfg", cfg_reg, MRC_CFG_RESET);
    check("irq_enable", {7'h00, global_irq_enable}, 8'h00);
    t_cfg_load();
    t_move();
    t_irq_ret();
    t_idle();
    complete_run();
  end
  // Watchdog
  initial
  begin
    #20000;
    mismatches++;
    complete_run();
  end
endmodule : misc_move_return_config_exec_test
`default_nettype wire
